// ===== ttc_regs.vh
// Constants for the thermal throttle control block: field positions, reset values, timing figures.
// Assumes a 100 MHz core clock; times are given in nanoseconds and converted to cycles.
`ifndef TTC_REGS_VH
`define TTC_REGS_VH
`define TTC_CLK_PERIOD_NS      10
// Clock duty throttle register fields.
`define TTC_CDT_FORCE_BIT      4
`define TTC_CDT_DUTY_MSB       3
`define TTC_CDT_DUTY_LSB       1
`define TTC_CDT_RESET          5'h00
// Modulation period in eighths; off time must stay within the longest off interval.
`define TTC_OFF_MAX_NS         3000
`define TTC_OFF_MAX_CYC        (`TTC_OFF_MAX_NS / `TTC_CLK_PERIOD_NS)
`define TTC_EIGHTH_CYC         (`TTC_OFF_MAX_CYC / 8)
// Factory duty cycle for thermal throttling, in eighths of on-time (50 percent).
`define TTC_FACTORY_DUTY       3'h4
// Frequency switch time, longest.
`define TTC_FSW_NS             5000
`define TTC_FSW_CYC            (`TTC_FSW_NS / `TTC_CLK_PERIOD_NS)
// Hysteresis time after cool-down.
`define TTC_HYST_NS            100000
`define TTC_HYST_CYC           (`TTC_HYST_NS / `TTC_CLK_PERIOD_NS)
// Interval between voltage-select steps.
`define TTC_VSTEP_NS           1000
`define TTC_VSTEP_CYC          (`TTC_VSTEP_NS / `TTC_CLK_PERIOD_NS)
// Hot interrupt edge select codes.
`define TTC_IRQ_NONE           2'h0
`define TTC_IRQ_RISE           2'h1
`define TTC_IRQ_FALL           2'h2
`define TTC_IRQ_BOTH           2'h3
`endif

// ===== ttc_duty_gen.v
// Clock duty generator: splits a modulation period into eight slots and gates on n of them.
// Assumes a same-clock enable and duty; duty zero yields no on-time, the caller filters it.
`timescale 1ns/10ps
`default_nettype none
module ttc_duty_gen #(
    parameter integer SLOT_CYC = 37
) (
    input  wire       i_sys_clk,
    input  wire       i_srst,
    input  wire       i_run,
    input  wire [2:0] i_duty,
    output reg        o_clk_on
);
    reg [15:0] slot_cnt_r;
    reg [2:0]  slot_r;

    // Slot counter; restarts whenever modulation stops so each period begins with on-time.
    always @(posedge i_sys_clk) begin
        if (i_srst || !i_run) begin
            slot_cnt_r <= 16'h0000;
            slot_r     <= 3'h0;
            o_clk_on   <= 1'b1;
        end else begin
            if (slot_cnt_r == SLOT_CYC[15:0] - 16'h0001) begin
                slot_cnt_r <= 16'h0000;
                slot_r     <= slot_r + 3'h1;
            end else begin
                slot_cnt_r <= slot_cnt_r + 16'h0001;
            end
            o_clk_on <= (slot_r < i_duty);
        end
    end
endmodule
`default_nettype wire

// ===== ttc_top.v
// Thermal throttle control: clock modulation, frequency/voltage throttling, forced duty, hot indication.
// Assumes the trip input is an asynchronous pin; software controls are same-clock inputs.
`timescale 1ns/10ps
`default_nettype none
`include "ttc_regs.vh"
module ttc_top #(
    parameter integer HYST_CYC  = `TTC_HYST_CYC,
    parameter integer VSTEP_CYC = `TTC_VSTEP_CYC,
    parameter [7:0]   LOW_RATIO = 8'h0C,
    parameter [5:0]   LOW_VSEL  = 6'h20
) (
    input  wire       i_sys_clk,
    input  wire       i_srst,
    input  wire       i_die_trip,
    input  wire       i_clk_throttle_en,
    input  wire       i_fv_throttle_en,
    input  wire [4:0] i_clk_duty_throttle,
    input  wire [7:0] i_ratio_sel,
    input  wire [5:0] i_normal_vsel,
    input  wire       i_ratio_wr,
    input  wire [1:0] i_hot_irq_sel,
    input  wire       i_irq_req,
    input  wire       i_edge_irq_req,
    output reg        o_die_hot_indicator,
    output reg        o_core_clk_on,
    output reg        o_throttle_active,
    output reg  [7:0] o_bus_ratio,
    output reg  [5:0] o_voltage_select_code,
    output reg        o_bus_block,
    output reg        o_irq_service,
    output reg        o_edge_irq_service,
    output reg        o_hot_irq,
    output reg        o_fv_busy
);
    // Frequency/voltage sequencer states, in the order a throttle episode walks them.
    // NORMAL holds the software ratio and the normal voltage code and watches for throttling.
    // FSW parks the ratio at the low value and blocks the bus while the core clock settles.
    // VDOWN walks the voltage code one table entry per step towards the low code.
    // LOW holds the low point until the throttle circuit has cooled and its hysteresis has run out.
    // VUP walks the voltage code back to the normal code, one entry per step.
    // FUP restores the ratio last written by software, which may have changed meanwhile.
    // The ratio never rises while the voltage is below normal, so the core is never starved.
    // The voltage never falls while the ratio is still high, for the same reason.
    // Limitation: a new normal code written mid-episode is only reached on the way back up.
    localparam [2:0] FV_NORMAL = 3'h0;
    localparam [2:0] FV_FSW    = 3'h1;
    localparam [2:0] FV_VDOWN  = 3'h2;
    localparam [2:0] FV_LOW    = 3'h3;
    localparam [2:0] FV_VUP    = 3'h4;
    localparam [2:0] FV_FUP    = 3'h5;

    reg        trip_s1_r;
    reg        trip_s2_r;
    reg        hot_d_r;
    reg        tcc_r;
    reg [23:0] hyst_cnt_r;
    reg [2:0]  fv_st_r;
    reg [15:0] fv_cnt_r;
    reg [7:0]  ratio_cur_r;
    reg        irq_pend_r;
    reg        edge_pend_r;
    reg        mod_run;
    reg [2:0]  mod_duty;
    wire       duty_on;
    wire [2:0] sw_duty;
    wire       sw_force;

    // Two-stage synchroniser on the internal trip comparator; the threshold lives outside this logic.
    // Fixed internal threshold
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            trip_s1_r <= 1'b0;
            trip_s2_r <= 1'b0;
        end else begin
            trip_s1_r <= i_die_trip;
            trip_s2_r <= trip_s1_r;
        end
    end

    // Hot indicator and edge interrupt; the indicator does not depend on any enable.
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            hot_d_r             <= 1'b0;
            o_die_hot_indicator <= 1'b0;
            o_hot_irq           <= 1'b0;
        end else begin
            hot_d_r <= trip_s2_r;
            o_die_hot_indicator <= trip_s2_r;
            o_hot_irq <= ((i_hot_irq_sel == `TTC_IRQ_RISE || i_hot_irq_sel == `TTC_IRQ_BOTH) &&
                          trip_s2_r && !hot_d_r) ||
                         ((i_hot_irq_sel == `TTC_IRQ_FALL || i_hot_irq_sel == `TTC_IRQ_BOTH) &&
                          !trip_s2_r && hot_d_r);
        end
    end

    // Throttle circuit activity with hysteresis, so a die hovering at the trip point cannot chatter.
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            tcc_r      <= 1'b0;
            hyst_cnt_r <= 24'h000000;
        end else if (trip_s2_r && (i_clk_throttle_en || i_fv_throttle_en)) begin
            tcc_r      <= 1'b1;
            hyst_cnt_r <= 24'h000000;
        end else if (tcc_r) begin
            if (hyst_cnt_r == HYST_CYC[23:0] - 24'h000001) begin
                tcc_r      <= 1'b0;
                hyst_cnt_r <= 24'h000000;
            end else begin
                hyst_cnt_r <= hyst_cnt_r + 24'h000001;
            end
        end
    end

    assign sw_force = i_clk_duty_throttle[`TTC_CDT_FORCE_BIT];
    assign sw_duty  = i_clk_duty_throttle[`TTC_CDT_DUTY_MSB:`TTC_CDT_DUTY_LSB];

    // Modulation source select; thermal throttling in clock mode wins over the software duty.
    always @* begin
        mod_run  = 1'b0;
        mod_duty = sw_duty;
        if (tcc_r && i_clk_throttle_en) begin
            mod_run  = 1'b1;
            mod_duty = `TTC_FACTORY_DUTY;
        end else if (sw_force && sw_duty != 3'h0) begin
            mod_run = 1'b1;
        end
    end

    ttc_duty_gen #(
        .SLOT_CYC (`TTC_EIGHTH_CYC)
    ) u_duty (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_run     (mod_run),
        .i_duty    (mod_duty),
        .o_clk_on  (duty_on)
    );

    // Frequency/voltage sequencer: ratio drops before voltage, and voltage rises before ratio.
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            fv_st_r               <= FV_NORMAL;
            fv_cnt_r              <= 16'h0000;
            o_bus_ratio           <= 8'h00;
            o_voltage_select_code <= 6'h00;
            o_bus_block           <= 1'b0;
            o_fv_busy             <= 1'b0;
        end else begin
            case (fv_st_r)
                FV_NORMAL: begin
                    o_bus_ratio           <= ratio_cur_r;
                    o_voltage_select_code <= i_normal_vsel;
                    o_fv_busy             <= 1'b0;
                    if (tcc_r && i_fv_throttle_en) begin
                        fv_st_r     <= FV_FSW;
                        fv_cnt_r    <= 16'h0000;
                        o_bus_block <= 1'b1;
                        o_bus_ratio <= LOW_RATIO;
                        o_fv_busy   <= 1'b1;
                    end
                end
                FV_FSW: begin
                    if (fv_cnt_r == `TTC_FSW_CYC - 1) begin
                        fv_st_r     <= FV_VDOWN;
                        fv_cnt_r    <= 16'h0000;
                        o_bus_block <= 1'b0;
                    end else begin
                        fv_cnt_r <= fv_cnt_r + 16'h0001;
                    end
                end
                FV_VDOWN, FV_VUP: begin
                    if (fv_cnt_r == VSTEP_CYC[15:0] - 16'h0001) begin
                        fv_cnt_r <= 16'h0000;
                        if (fv_st_r == FV_VDOWN) begin
                            if (o_voltage_select_code == LOW_VSEL)
                                fv_st_r <= FV_LOW;
                            else if (o_voltage_select_code < LOW_VSEL)
                                o_voltage_select_code <= o_voltage_select_code + 6'h01;
                            else
                                o_voltage_select_code <= o_voltage_select_code - 6'h01;
                        end else begin
                            if (o_voltage_select_code == i_normal_vsel)
                                fv_st_r <= FV_FUP;
                            else if (o_voltage_select_code < i_normal_vsel)
                                o_voltage_select_code <= o_voltage_select_code + 6'h01;
                            else
                                o_voltage_select_code <= o_voltage_select_code - 6'h01;
                        end
                    end else begin
                        fv_cnt_r <= fv_cnt_r + 16'h0001;
                    end
                end
                FV_LOW: begin
                    if (!tcc_r) begin
                        fv_st_r  <= FV_VUP;
                        fv_cnt_r <= 16'h0000;
                    end
                end
                FV_FUP: begin
                    o_bus_ratio <= ratio_cur_r;
                    fv_st_r     <= FV_NORMAL;
                end
                default: begin
                    fv_st_r <= FV_NORMAL;
                end
            endcase
        end
    end

    // Ratio requests are only stored here; the sequencer applies them at the normal point.
    // Storing rather than applying keeps a software raise from undercutting the low voltage.
    // Defer higher frequency
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            ratio_cur_r <= 8'h00;
        end else if (i_ratio_wr) begin
            ratio_cur_r <= i_ratio_sel;
        end
    end

    // Interrupt latching; a new request in the service cycle is kept, so no event is lost.
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq_pend_r         <= 1'b0;
            edge_pend_r        <= 1'b0;
            o_irq_service      <= 1'b0;
            o_edge_irq_service <= 1'b0;
            o_core_clk_on      <= 1'b1;
            o_throttle_active  <= 1'b0;
        end else begin
            o_core_clk_on     <= duty_on;
            o_throttle_active <= tcc_r;
            o_irq_service <= (irq_pend_r || i_irq_req) && duty_on;
            irq_pend_r    <= i_irq_req || (irq_pend_r && !duty_on);
            o_edge_irq_service <= (edge_pend_r || i_edge_irq_req) && duty_on && (fv_st_r != FV_FSW);
            edge_pend_r        <= i_edge_irq_req || (edge_pend_r && !(duty_on && fv_st_r != FV_FSW));
        end
    end
endmodule
`default_nettype wire

// ===== ttc_vreg_model.sv
// Voltage regulator stand-in that watches the voltage-select code.
// Assumes the same core clock; codes are only checked while the block is away from its normal point.
`timescale 1ns/10ps
`default_nettype none
module ttc_vreg_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    input  wire logic       i_busy,
    input  wire logic [5:0] i_vsel,
    output var  logic       o_step_err
);
    logic       busy_r;
    logic [5:0] last_r;
    // accept dynamic steps
    // A jump wider than one table entry between two busy cycles is flagged, because a real supply could droop on it.
    always @(posedge i_sys_clk) begin
        busy_r <= i_busy && !i_srst;
        last_r <= i_vsel;
        if (i_srst)
            o_step_err <= 1'b0;
        else if (busy_r && i_busy && i_vsel != last_r && i_vsel != last_r + 6'h01 && i_vsel != last_r - 6'h01)
            o_step_err <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== ttc_checker.sv
// Concurrent checks on the ports of the thermal throttle block.
// Assumes one core clock and its synchronous reset; bound into every instance below.
`timescale 1ns/10ps
`default_nettype none
module ttc_checker #(
    parameter integer HYST_CYC  = 20,
    parameter integer VSTEP_CYC = 4,
    parameter [7:0]   LOW_RATIO = 8'h0C
) (
    input wire logic       i_sys_clk,
    input wire logic       i_srst,
    input wire logic       i_die_trip,
    input wire logic       i_clk_throttle_en,
    input wire logic       i_fv_throttle_en,
    input wire logic [4:0] i_clk_duty_throttle,
    input wire logic [7:0] i_ratio_sel,
    input wire logic [5:0] i_normal_vsel,
    input wire logic       i_ratio_wr,
    input wire logic [1:0] i_hot_irq_sel,
    input wire logic       i_irq_req,
    input wire logic       i_edge_irq_req,
    input wire logic       o_die_hot_indicator,
    input wire logic       o_core_clk_on,
    input wire logic       o_throttle_active,
    input wire logic [7:0] o_bus_ratio,
    input wire logic [5:0] o_voltage_select_code,
    input wire logic       o_bus_block,
    input wire logic       o_irq_service,
    input wire logic       o_edge_irq_service,
    input wire logic       o_hot_irq,
    input wire logic       o_fv_busy
);
    logic [9:0] off_r;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // Length of the current clock-off run; it saturates so a stuck clock never wraps to a pass.
    always @(posedge i_sys_clk) begin
        if (i_srst || o_core_clk_on) off_r <= 10'h000;
        else if (off_r != 10'h3FF) off_r <= off_r + 10'h001;
    end
    a_hot_follows_trip: assert property (!$past(i_srst) && !$past(i_srst, 3) |->
        o_die_hot_indicator == $past(i_die_trip, 3)) else $error("hot indicator lags trip wrongly");
    a_off_bounded: assert property (off_r <= 10'h12C) else $error("clock off too long");
    a_idle_clk_runs: assert property (!o_throttle_active && !$past(o_throttle_active) &&
        !$past(o_throttle_active, 2) && !i_clk_duty_throttle[4] && !$past(i_clk_duty_throttle[4])
        && !$past(i_clk_duty_throttle[4], 2) |-> o_core_clk_on) else $error("clock stopped when idle");
    a_hot_irq_edge: assert property (($rose(o_die_hot_indicator) && i_hot_irq_sel[0]) ||
        ($fell(o_die_hot_indicator) && i_hot_irq_sel[1]) |-> o_hot_irq) else $error("hot irq missing");
    a_throttle_starts: assert property ($rose(o_die_hot_indicator) &&
        (i_clk_throttle_en || i_fv_throttle_en) |=> o_throttle_active) else $error("throttle late");
    a_throttle_while_hot: assert property (o_die_hot_indicator && $past(o_die_hot_indicator) &&
        i_clk_throttle_en && $past(i_clk_throttle_en) |-> o_throttle_active) else $error("throttle dropped");
    a_switch_bounded: assert property ($rose(o_bus_block) |-> ##[1:500] !o_bus_block)
        else $error("frequency switch too long");
    a_vsel_one_step: assert property (o_fv_busy && $past(o_fv_busy) && $changed(o_voltage_select_code)
        |-> (o_voltage_select_code - $past(o_voltage_select_code) == 6'h01) ||
        ($past(o_voltage_select_code) - o_voltage_select_code == 6'h01)) else $error("code jumped");
    a_volt_before_freq: assert property ($changed(o_bus_ratio) && $past(o_fv_busy) &&
        o_bus_ratio != LOW_RATIO |-> o_voltage_select_code == i_normal_vsel) else $error("ratio before code");
endmodule
bind ttc_top ttc_checker #(.HYST_CYC(HYST_CYC), .VSTEP_CYC(VSTEP_CYC), .LOW_RATIO(LOW_RATIO)) u_chk (.*);
`default_nettype wire

// ===== ttc_top_bench.sv
// Self-checking bench for the thermal throttle block with a regulator stand-in.
// Assumes shortened hysteresis and step timers; the checker binds itself.
`timescale 1ns/10ps
`default_nettype none
module ttc_top_bench;
    logic        clk = 1'b0, rst = 1'b1, trip = 1'b0, cen = 1'b0, fen = 1'b0;
    logic        rwr = 1'b0, irq = 1'b0, eirq = 1'b0;
    logic [4:0]  cdt = 5'h00;
    logic [7:0]  rsel = 8'h00, ratio;
    logic [5:0]  nvs = 6'h28, vsel;
    logic [1:0]  isel = 2'h3;
    logic        hot, con, act, blk, isv, esv, hirq, busy, verr;
    integer      bad_count = 0, cmp_count = 0, n, k, e, hits = 0;
    // Rows pack the duty register setting over the on-cycles expected in one 296-cycle period.
    logic [15:0] rows [0:8] = '{16'h9025, 16'hA04A, 16'hB06F, 16'hC094, 16'hD0B9, 16'hE0DE,
                                16'hF103, 16'h8128, 16'h7928};
    ttc_top #(.HYST_CYC(20), .VSTEP_CYC(4)) u_dut (.i_sys_clk(clk), .i_srst(rst), .i_die_trip(trip),
        .i_clk_throttle_en(cen), .i_fv_throttle_en(fen), .i_clk_duty_throttle(cdt), .i_ratio_sel(rsel),
        .i_normal_vsel(nvs), .i_ratio_wr(rwr), .i_hot_irq_sel(isel), .i_irq_req(irq), .i_edge_irq_req(eirq),
        .o_die_hot_indicator(hot), .o_core_clk_on(con), .o_throttle_active(act), .o_bus_ratio(ratio),
        .o_voltage_select_code(vsel), .o_bus_block(blk), .o_irq_service(isv), .o_edge_irq_service(esv),
        .o_hot_irq(hirq), .o_fv_busy(busy));
    ttc_vreg_model u_vreg (.i_sys_clk(clk), .i_srst(rst), .i_busy(busy), .i_vsel(vsel), .o_step_err(verr));
    always #5 clk = ~clk;
    // Hot interrupt pulses are tallied so each scenario can count edges.
    always @(negedge clk) if (hirq === 1'b1) hits++;
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Counts clock-on cycles over one full period, so the phase of the window does not matter.
    task automatic on_count(output integer cnt);
        cnt = 0;
        repeat (296) begin @(negedge clk); cnt += con; end
    endtask
    task automatic conclude;
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        // The scenarios need about 7000 cycles; 20000 leaves ample margin.
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("reset outputs", {hot, con, act, blk, isv, esv, hirq, busy, ratio}, 16'h4000);
        @(posedge clk); rsel <= 8'h10; rwr <= 1'b1;
        @(posedge clk); rwr <= 1'b0;
        for (k = 0; k < 9; k++) begin
            @(posedge clk); cdt <= rows[k][15:11];
            repeat (310) @(negedge clk);
            on_count(n);
            check("forced on cycles", n[15:0], {5'h00, rows[k][10:0]});
        end
        // Hot die in clock mode while a quarter duty is forced: the factory half duty must win.
        @(posedge clk); cdt <= 5'h14; cen <= 1'b1; trip <= 1'b1; hits = 0;
        repeat (6) @(negedge clk);
        check("hot and active", {hot, act}, 16'h0003);
        repeat (300) @(negedge clk);
        on_count(n);
        check("thermal on cycles", n[15:0], 16'h0094);
        // An interrupt raised in an off slot waits for a clock-on cycle.
        k = 0;
        while (con !== 1'b0 && k < 300) begin @(negedge clk); k++; end
        @(posedge clk); irq <= 1'b1;
        @(posedge clk); irq <= 1'b0;
        k = 0;
        while (isv !== 1'b1 && k < 300) begin @(negedge clk); k++; end
        n = con;
        check("irq served in on cycle", {isv, n[0]}, 16'h0003);
        @(posedge clk); trip <= 1'b0; cdt <= 5'h00;
        repeat (12) @(negedge clk);
        check("held by hysteresis", act, 16'h0001);
        repeat (40) @(negedge clk);
        check("released and two edges", {act, hits[1:0]}, 16'h0002);
        // Hot with no mode enabled still shows the indicator but never throttles.
        @(posedge clk); cen <= 1'b0; isel <= 2'h0; trip <= 1'b1; hits = 0;
        repeat (8) @(negedge clk);
        check("hot without modes", {hot, act, hits[1:0]}, 16'h0008);
        // Both throttle modes were also off in the forced-duty sweep; from the next scenario on, frequency/voltage mode stays enabled.
        @(posedge clk); trip <= 1'b0; isel <= 2'h1;
        repeat (8) @(negedge clk);
        // Frequency/voltage mode: switch, then step down, with an edge interrupt during the switch.
        @(posedge clk); fen <= 1'b1; trip <= 1'b1; hits = 0;
        k = 0;
        while (blk !== 1'b1 && k < 20) begin @(negedge clk); k++; end
        @(posedge clk); eirq <= 1'b1;
        @(posedge clk); eirq <= 1'b0;
        n = 2;
        e = 0;
        // Only negedges that still see the block count, so n is the blocked span in cycles.
        while (blk === 1'b1 && n < 600) begin
            @(negedge clk);
            if (blk === 1'b1) n++;
            if (esv === 1'b1) e = 1;
        end
        check("low ratio in time", {ratio, 7'h00, n <= 500}, 16'h0C01);
        k = 0;
        while (esv !== 1'b1 && k < 10) begin @(negedge clk); k++; end
        check("edge irq held", {e[0], esv}, 16'h0001);
        @(posedge clk); rsel <= 8'h14; rwr <= 1'b1;
        @(posedge clk); rwr <= 1'b0;
        k = 0;
        while (vsel !== 6'h20 && k < 100) begin @(negedge clk); k++; end
        check("low point", {ratio, vsel, verr, 1'b0}, 16'h0C80);
        @(posedge clk); trip <= 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 400) begin @(negedge clk); k++; end
        check("normal point", {ratio, vsel, hits[1:0]}, 16'h14A1);
        conclude();
    end
endmodule
`default_nettype wire
